// File: verilog/msd_consts.vh
// Constants for the memory space decoder: offsets, field positions, reset values.
// Assumes inclusion by bare name from the decoder's design files.
`ifndef MSD_CONSTS_VH
`define MSD_CONSTS_VH

`define MSD_FLASH_FIRST      16'h0000
`define MSD_FLASH_LAST       16'h3DFF
`define MSD_LOCK_BYTE_ADDR   16'h3DFF
`define MSD_SFR_FIRST        8'h80
`define MSD_LOW_RAM_LAST     8'h7F
`define MSD_BANK_AREA_LAST   8'h1F
`define MSD_BIT_AREA_FIRST   8'h20
`define MSD_BIT_AREA_LAST    8'h2F
`define MSD_PAGE_REG_ADDR    8'hAA
`define MSD_PAGE_REG_RESET   8'h00
`define MSD_SP_RESET         8'h07
`define MSD_PSW_ADDR         8'hD0
`define MSD_SP_ADDR          8'h81
`define MSD_PSW_BANK_LO      3
`define MSD_PSW_BANK_HI      4
`define MSD_ONCHIP_EXTERNAL_RAM_AW          9

// Access kinds presented by the core.
`define MSD_OP_NONE          3'd0
`define MSD_OP_DIRECT        3'd1
`define MSD_OP_INDIRECT      3'd2
`define MSD_OP_BIT           3'd3
`define MSD_OP_PUSH          3'd4
`define MSD_OP_POP           3'd5
`define MSD_OP_XMOVE         3'd6
`define MSD_OP_CMOVE         3'd7

`endif

// File: verilog/msd_ram.v
// Single-port synchronous byte RAM with write enable.
// Assumes one clock; read data appears one edge after the address.
`timescale 1ns/1ps
`default_nettype none

module msd_ram #(
  parameter AW = 8
) (
  input  wire          clk,
  input  wire          we,
  input  wire [AW-1:0] addr,
  input  wire [7:0]    wdata,
  output reg  [7:0]    rdata
);

  reg [7:0] mem [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule

`default_nettype wire

// File: verilog/msd_decoder.v
// Memory space decoder: internal RAM, banks, bit area, stack, ONCHIP_EXTERNAL_RAM and flash routing.
// Assumes the core issues one access per OP_VALID pulse on the same clock; flash is outside.
//
// What this block does
// - Flash occupies 0x0000 to 0x3DFF.
// - Top flash byte is lock; above reserved.
// - Code reads flash; writes flash only when enabled.
// - Otherwise external moves use on-chip RAM.
// - Internal RAM 0x00-0xFF; low half any mode.
// - Above 0x7F: direct to SFRs, indirect upper RAM.
// - 0x00-0x1F hold four eight-register banks.
// - Status word bits 3,4 select bank.
// - Indirect address from bank reg zero/one.
// - Bytes 0x20-0x2F give 128 addressable bits.
// - Bit versus byte chosen by instruction type.
// - Push writes pointer plus one, then increments.
// - Reset pointer 0x07; first push at 0x08.
// - Stack anywhere in 256 bytes, full depth.
// - 512 bytes external RAM via pointer or indirect.
// - Register-operand moves take page register high byte.
// - Wide pointer ignores top seven bits; mirrored.
// - Page register bits 7:1 read zero.
// - Page bit picks 256-byte external page.
// - Bank codes 00..11 map banks 0..3.
// - Direct 0x80-0xFF decoded as SPECIAL_FUNCTION_SPACE space.
`timescale 1ns/1ps
`default_nettype none
`include "msd_consts.vh"

module msd_decoder (
  input  wire        CLK,
  input  wire        RST,
  input  wire        OP_VALID,
  input  wire [2:0]  OP_KIND,
  input  wire        OP_WRITE,
  input  wire [7:0]  OP_ADDR,
  input  wire [2:0]  OP_REG_SEL,
  input  wire        OP_USE_REG,
  input  wire        OP_WIDE,
  input  wire [15:0] OP_WIDE_ADDR,
  input  wire [7:0]  OP_WDATA,
  input  wire        OP_BIT_WDATA,
  input  wire        FLASH_WRITE_EN,
  output reg         RESP_VALID,
  output reg  [7:0]  RESP_RDATA,
  output reg         RESP_BIT,
  output reg         SFR_SEL,
  output reg         SFR_WRITE,
  output reg  [7:0]  SFR_ADDR,
  output reg  [7:0]  SFR_WDATA,
  output reg         FLASH_READ,
  output reg         FLASH_WRITE,
  output reg  [15:0] FLASH_ADDR,
  output reg         FLASH_RESERVED,
  output reg         FLASH_LOCK_SEL,
  output reg  [7:0]  FLASH_WDATA,
  output reg  [7:0]  STACK_POINTER,
  output reg  [1:0]  ACTIVE_BANK,
  output reg         ONCHIP_EXTERNAL_RAM_PAGE_BIT
);

  // **********************************************************
  // Architectural registers owned by the decoder
  // **********************************************************
  reg  [7:0] sp_q;
  reg  [7:0] sp_d;
  reg  [1:0] bank_q;
  reg  [1:0] bank_d;
  reg        page_q;
  reg        page_d;

  // **********************************************************
  // Request sequencer
  // **********************************************************
  // Indirect and bit accesses need a second RAM cycle, so the sequencer
  // reads the pointer or byte first and finishes the access afterwards.
  localparam ST_IDLE   = 3'd0;
  localparam ST_PTR    = 3'd1;
  localparam ST_ACCESS = 3'd2;
  localparam ST_BITRD  = 3'd3;
  localparam ST_BITWR  = 3'd4;
  localparam ST_XRD    = 3'd5;
  localparam ST_DONE   = 3'd6;

  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [2:0]  kind_q;
  reg  [2:0]  kind_d;
  reg         wr_q;
  reg         wr_d;
  reg  [7:0]  wdata_q;
  reg  [7:0]  wdata_d;
  reg  [2:0]  bitpos_q;
  reg  [2:0]  bitpos_d;
  reg         bitval_q;
  reg         bitval_d;
  reg  [7:0]  addr_q;
  reg  [7:0]  addr_d;

  reg         ram_we;
  reg  [7:0]  ram_addr;
  reg  [7:0]  ram_wdata;
  wire [7:0]  ram_rdata;
  reg         onchip_external_ram_we;
  reg  [8:0]  onchip_external_ram_addr;
  wire [7:0]  onchip_external_ram_rdata;

  reg         resp_valid_d;
  reg  [7:0]  resp_rdata_d;
  reg         resp_bit_d;
  reg         sfr_sel_d;
  reg         sfr_write_d;
  reg  [7:0]  sfr_addr_d;
  reg         flash_read_d;
  reg         flash_write_d;
  reg  [15:0] flash_addr_d;
  reg         flash_rsv_d;

  reg  [15:0] xaddr;
  reg  [7:0]  bitbyte;
  reg  [7:0]  merged;

  msd_ram #(
    .AW(8)
  ) u_iram (
    .clk   (CLK),
    .we    (ram_we),
    .addr  (ram_addr),
    .wdata (ram_wdata),
    .rdata (ram_rdata)
  );

  msd_ram #(
    .AW(`MSD_ONCHIP_EXTERNAL_RAM_AW)
  ) u_onchip_external_ram (
    .clk   (CLK),
    .we    (onchip_external_ram_we),
    .addr  (onchip_external_ram_addr),
    .wdata (OP_WDATA),
    .rdata (onchip_external_ram_rdata)
  );

  always @* begin
    state_d       = state_q;
    kind_d        = kind_q;
    wr_d          = wr_q;
    wdata_d       = wdata_q;
    bitpos_d      = bitpos_q;
    bitval_d      = bitval_q;
    addr_d        = addr_q;
    sp_d          = sp_q;
    bank_d        = bank_q;
    page_d        = page_q;
    ram_we        = 1'b0;
    ram_addr      = 8'h00;
    ram_wdata     = wdata_q;
    onchip_external_ram_we       = 1'b0;
    onchip_external_ram_addr     = 9'h000;
    resp_valid_d  = 1'b0;
    resp_rdata_d  = RESP_RDATA;
    resp_bit_d    = RESP_BIT;
    sfr_sel_d     = 1'b0;
    sfr_write_d   = 1'b0;
    sfr_addr_d    = SFR_ADDR;
    flash_read_d  = 1'b0;
    flash_write_d = 1'b0;
    flash_addr_d  = FLASH_ADDR;
    flash_rsv_d   = 1'b0;
    xaddr         = 16'h0000;
    bitbyte       = 8'h00;
    merged        = ram_rdata;
    case (state_q)
      ST_IDLE: begin
        if (OP_VALID) begin
          kind_d  = OP_KIND;
          wr_d    = OP_WRITE;
          wdata_d = OP_WDATA;
          ram_wdata = OP_WDATA;
          addr_d  = OP_ADDR;
          case (OP_KIND)
            `MSD_OP_DIRECT: begin
              if (OP_USE_REG) begin
                // Register operand: bank number forms address bits 4:3.
                ram_addr = {3'b000, bank_q, OP_REG_SEL};
                ram_we   = OP_WRITE;
                state_d  = ST_DONE;
              end else if (OP_ADDR >= `MSD_SFR_FIRST) begin
                sfr_sel_d   = 1'b1;
                sfr_write_d = OP_WRITE;
                sfr_addr_d  = OP_ADDR;
                if (OP_WRITE && OP_ADDR == `MSD_PAGE_REG_ADDR) begin
                  page_d = OP_WDATA[0];
                end
                if (OP_WRITE && OP_ADDR == `MSD_PSW_ADDR) begin
                  bank_d = {OP_WDATA[`MSD_PSW_BANK_HI], OP_WDATA[`MSD_PSW_BANK_LO]};
                end
                if (OP_WRITE && OP_ADDR == `MSD_SP_ADDR) begin
                  sp_d = OP_WDATA;
                end
                state_d = ST_DONE;
              end else begin
                ram_addr = OP_ADDR;
                ram_we   = OP_WRITE;
                state_d  = ST_DONE;
              end
            end
            `MSD_OP_INDIRECT, `MSD_OP_XMOVE: begin
              if (OP_KIND == `MSD_OP_XMOVE && OP_WIDE) begin
                state_d = ST_ACCESS;
              end else begin
                // Pointer comes from bank register zero or one.
                ram_addr = {3'b000, bank_q, 2'b00, OP_REG_SEL[0]};
                state_d  = ST_PTR;
              end
            end
            `MSD_OP_BIT: begin
              // Bit number 8*(byte-0x20)+pos, so byte is 0x20+bit[6:3].
              ram_addr = {4'h2, OP_ADDR[6:3]};
              bitpos_d = OP_ADDR[2:0];
              bitval_d = OP_BIT_WDATA;
              state_d  = ST_BITRD;
            end
            `MSD_OP_PUSH: begin
              ram_addr = sp_q + 8'h01;
              ram_we   = 1'b1;
              sp_d     = sp_q + 8'h01;
              state_d  = ST_DONE;
            end
            `MSD_OP_POP: begin
              ram_addr = sp_q;
              sp_d     = sp_q - 8'h01;
              state_d  = ST_DONE;
            end
            `MSD_OP_CMOVE: begin
              flash_read_d = OP_WIDE_ADDR <= `MSD_FLASH_LAST;
              flash_addr_d = OP_WIDE_ADDR;
              flash_rsv_d  = OP_WIDE_ADDR > `MSD_FLASH_LAST;
              state_d      = ST_DONE;
            end
            default: begin
              resp_valid_d = 1'b1;
            end
          endcase
        end
      end
      ST_PTR: begin
        addr_d  = ram_rdata;
        state_d = ST_ACCESS;
      end
      ST_ACCESS: begin
        if (kind_q == `MSD_OP_INDIRECT) begin
          // Indirect reaches all 256 bytes, never the SFRs.
          ram_addr = addr_q;
          ram_we   = wr_q;
          state_d  = ST_DONE;
        end else begin
          if (OP_WIDE) begin
            xaddr = OP_WIDE_ADDR;
          end else begin
            xaddr = {7'h00, page_q, addr_q};
          end
          if (FLASH_WRITE_EN && wr_q) begin
            flash_write_d = xaddr <= `MSD_FLASH_LAST;
            flash_addr_d  = xaddr;
            flash_rsv_d   = xaddr > `MSD_FLASH_LAST;
            state_d       = ST_DONE;
          end else begin
            onchip_external_ram_addr = xaddr[8:0];
            onchip_external_ram_we   = wr_q;
            state_d   = ST_XRD;
          end
        end
      end
      ST_XRD: begin
        resp_valid_d = 1'b1;
        resp_rdata_d = onchip_external_ram_rdata;
        state_d      = ST_IDLE;
      end
      ST_BITRD: begin
        ram_addr = {4'h2, addr_q[6:3]};
        state_d = ST_BITWR;
      end
      ST_BITWR: begin
        bitbyte    = ram_rdata;
        resp_bit_d = bitbyte[bitpos_q];
        merged     = bitbyte;
        merged[bitpos_q] = bitval_q;
        ram_addr   = {4'h2, addr_q[6:3]};
        ram_wdata  = merged;
        ram_we     = wr_q;
        resp_rdata_d = bitbyte;
        resp_valid_d = 1'b1;
        state_d    = ST_IDLE;
      end
      ST_DONE: begin
        resp_valid_d = 1'b1;
        resp_rdata_d = (SFR_SEL && SFR_ADDR == `MSD_PAGE_REG_ADDR) ? {7'h00, page_q} : ram_rdata;
        state_d      = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge CLK) begin
    if (RST) begin
      state_q        <= ST_IDLE;
      kind_q         <= `MSD_OP_NONE;
      wr_q           <= 1'b0;
      wdata_q        <= 8'h00;
      bitpos_q       <= 3'h0;
      bitval_q       <= 1'b0;
      addr_q         <= 8'h00;
      sp_q           <= `MSD_SP_RESET;
      bank_q         <= 2'b00;
      page_q         <= 1'b0;
      RESP_VALID     <= 1'b0;
      RESP_RDATA     <= 8'h00;
      RESP_BIT       <= 1'b0;
      SFR_SEL        <= 1'b0;
      SFR_WRITE      <= 1'b0;
      SFR_ADDR       <= 8'h00;
      SFR_WDATA      <= 8'h00;
      FLASH_READ     <= 1'b0;
      FLASH_WRITE    <= 1'b0;
      FLASH_ADDR     <= 16'h0000;
      FLASH_RESERVED <= 1'b0;
      FLASH_LOCK_SEL <= 1'b0;
      FLASH_WDATA    <= 8'h00;
      STACK_POINTER  <= `MSD_SP_RESET;
      ACTIVE_BANK    <= 2'b00;
      ONCHIP_EXTERNAL_RAM_PAGE_BIT  <= 1'b0;
    end else begin
      state_q        <= state_d;
      kind_q         <= kind_d;
      wr_q           <= wr_d;
      wdata_q        <= wdata_d;
      bitpos_q       <= bitpos_d;
      bitval_q       <= bitval_d;
      addr_q         <= addr_d;
      sp_q           <= sp_d;
      bank_q         <= bank_d;
      page_q         <= page_d;
      RESP_VALID     <= resp_valid_d;
      RESP_RDATA     <= resp_rdata_d;
      RESP_BIT       <= resp_bit_d;
      SFR_SEL        <= sfr_sel_d;
      SFR_WRITE      <= sfr_write_d;
      SFR_ADDR       <= sfr_addr_d;
      SFR_WDATA      <= wdata_d;
      FLASH_READ     <= flash_read_d;
      FLASH_WRITE    <= flash_write_d;
      FLASH_ADDR     <= flash_addr_d;
      FLASH_RESERVED <= flash_rsv_d;
      FLASH_LOCK_SEL <= (flash_read_d || flash_write_d) && flash_addr_d == `MSD_LOCK_BYTE_ADDR;
      FLASH_WDATA    <= wdata_q;
      STACK_POINTER  <= sp_d;
      ACTIVE_BANK    <= bank_d;
      ONCHIP_EXTERNAL_RAM_PAGE_BIT  <= page_d;
    end
  end

endmodule

`default_nettype wire

// File: tb/msd_flash_model.sv
// Program flash as seen from the decoder's flash strobes.
// Assumes strobes are one-cycle pulses on the decoder clock.
`timescale 1ns/1ps
`default_nettype none
// ****
// Flash array
// ****
module msd_flash_model (
  input wire logic        clk,
  input wire logic        wr,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata
);
  // Only 0x0000 to 0x3DFF exists, so a stray write above it is lost.
  logic [7:0] mem [0:16'h3DFF];
  int         n_wr = 0;
  always @(posedge clk) begin
    if (wr) begin
      mem[addr] <= wdata;
      n_wr <= n_wr + 1;
    end
  end
endmodule
`default_nettype wire

// File: tb/msd_decoder_checker.sv
// Concurrent checks on the memory space decoder ports.
// Assumes the core waits for the response before its next request.
`timescale 1ns/1ps
`default_nettype none
// ****
// Checker
// ****
module msd_decoder_checker (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        OP_VALID,
  input wire logic [2:0]  OP_KIND,
  input wire logic        OP_WRITE,
  input wire logic [7:0]  OP_ADDR,
  input wire logic        OP_USE_REG,
  input wire logic [15:0] OP_WIDE_ADDR,
  input wire logic [7:0]  OP_WDATA,
  input wire logic        FLASH_WRITE_EN,
  input wire logic        RESP_VALID,
  input wire logic        SFR_SEL,
  input wire logic        SFR_WRITE,
  input wire logic [7:0]  SFR_ADDR,
  input wire logic [7:0]  SFR_WDATA,
  input wire logic        FLASH_READ,
  input wire logic        FLASH_WRITE,
  input wire logic        FLASH_RESERVED,
  input wire logic        FLASH_LOCK_SEL,
  input wire logic [7:0]  STACK_POINTER,
  input wire logic [1:0]  ACTIVE_BANK,
  input wire logic        ONCHIP_EXTERNAL_RAM_PAGE_BIT
);
  // Requests made while busy are ignored; the decoder is idle again while the response stands.
  logic busy_q;
  wire  tk = OP_VALID && (!busy_q || RESP_VALID);
  wire  dw = tk && OP_KIND == 3'd1 && !OP_USE_REG;
  always @(posedge CLK) begin
    if (RST) busy_q <= 1'b0;
    else if (tk) busy_q <= 1'b1;
    else if (RESP_VALID) busy_q <= 1'b0;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  property p_rst;
    disable iff (1'b0) RST |=> STACK_POINTER == 8'h07 && !RESP_VALID;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_psh;
    tk && OP_KIND == 3'd4 |-> ##2 RESP_VALID && STACK_POINTER == $past(STACK_POINTER, 2) + 8'd1;
  endproperty
  a_psh: assert property (p_psh) else $error("push pointer wrong");
  property p_pop;
    tk && OP_KIND == 3'd5 |-> ##2 RESP_VALID && STACK_POINTER == $past(STACK_POINTER, 2) - 8'd1;
  endproperty
  a_pop: assert property (p_pop) else $error("pop pointer wrong");
  property p_sfr;
    dw && OP_ADDR[7] |=> SFR_SEL && SFR_ADDR == $past(OP_ADDR)
      && SFR_WRITE == $past(OP_WRITE) && SFR_WDATA == $past(OP_WDATA);
  endproperty
  a_sfr: assert property (p_sfr) else $error("direct high not in SPECIAL_FUNCTION_SPACE space");
  property p_low;
    dw && !OP_ADDR[7] |=> !SFR_SEL ##1 RESP_VALID;
  endproperty
  a_low: assert property (p_low) else $error("direct low access wrong");
  property p_ind;
    tk && OP_KIND == 3'd2 |=> !SFR_SEL [*3] ##1 RESP_VALID;
  endproperty
  a_ind: assert property (p_ind) else $error("indirect reached SPECIAL_FUNCTION_SPACE space");
  property p_pg;
    dw && OP_WRITE && OP_ADDR == 8'hAA |=> ONCHIP_EXTERNAL_RAM_PAGE_BIT == $past(OP_WDATA[0]);
  endproperty
  a_pg: assert property (p_pg) else $error("page bit not loaded");
  property p_bnk;
    dw && OP_WRITE && OP_ADDR == 8'hD0 |-> ##2 ACTIVE_BANK == $past(OP_WDATA[4:3], 2);
  endproperty
  a_bnk: assert property (p_bnk) else $error("bank select wrong");
  property p_cmv;
    tk && OP_KIND == 3'd7 |=> FLASH_RESERVED == ($past(OP_WIDE_ADDR) > 16'h3DFF)
      && FLASH_READ == !FLASH_RESERVED && FLASH_LOCK_SEL == ($past(OP_WIDE_ADDR) == 16'h3DFF);
  endproperty
  a_cmv: assert property (p_cmv) else $error("code read routing wrong");
  property p_nfw;
    FLASH_WRITE |-> $past(FLASH_WRITE_EN);
  endproperty
  a_nfw: assert property (p_nfw) else $error("flash written while disabled");
  c_psh: cover property (tk && OP_KIND == 3'd4);
  c_rsv: cover property (FLASH_RESERVED);
  c_fw: cover property (FLASH_WRITE);
endmodule
bind msd_decoder msd_decoder_checker u_chk (.CLK, .RST, .OP_VALID, .OP_KIND, .OP_WRITE, .OP_ADDR,
  .OP_USE_REG, .OP_WIDE_ADDR, .OP_WDATA, .FLASH_WRITE_EN, .RESP_VALID, .SFR_SEL, .SFR_WRITE, .SFR_ADDR, .SFR_WDATA,
  .FLASH_READ, .FLASH_WRITE, .FLASH_RESERVED, .FLASH_LOCK_SEL, .STACK_POINTER, .ACTIVE_BANK,
  .ONCHIP_EXTERNAL_RAM_PAGE_BIT);
`default_nettype wire

// File: tb/msd_decoder_tb_top.sv
// Self-checking bench for the memory space decoder.
// Assumes one request at a time, each awaited until its response.
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench
// ****
module msd_decoder_tb_top;
  typedef struct packed {
    logic [2:0]  k, r;
    logic        w, u, x, c;
    logic [7:0]  a, d, e;
    logic [15:0] wa;
  } msd_row_t;
  logic        clk, rst, op_v, op_w, op_u, op_x, fl_en;
  logic [2:0]  op_k, op_r;
  logic [7:0]  op_a, op_d;
  logic [15:0] op_wa;
  wire         resp_v, rbit, fwr, pg;
  wire  [7:0]  rd, fwd, sp;
  wire  [15:0] faddr;
  wire  [1:0]  bank;
  int          n_errors = 0, checks = 0, cyc = 0;
  // Order is kind, reg, write, use_reg, wide, check, addr, data, expect, wide addr.
  msd_row_t rows [24] = '{
    '{4,0,1,0,0,0,8'h00,8'hA5,8'h00,16'h0}, '{1,0,0,0,0,1,8'h08,8'h00,8'hA5,16'h0},
    '{5,0,0,0,0,1,8'h00,8'h00,8'hA5,16'h0}, '{1,0,1,0,0,0,8'h30,8'h5A,8'h00,16'h0},
    '{1,0,1,1,0,0,8'h00,8'h30,8'h00,16'h0}, '{2,0,0,0,0,1,8'h00,8'h00,8'h5A,16'h0},
    '{1,1,1,1,0,0,8'h00,8'h90,8'h00,16'h0}, '{2,1,1,0,0,0,8'h00,8'hC3,8'h00,16'h0},
    '{2,1,0,0,0,1,8'h00,8'h00,8'hC3,16'h0}, '{1,0,1,0,0,0,8'hD0,8'h18,8'h00,16'h0},
    '{1,7,1,1,0,0,8'h00,8'h77,8'h00,16'h0}, '{1,0,1,0,0,0,8'hD0,8'h00,8'h00,16'h0},
    '{1,0,0,0,0,1,8'h1F,8'h00,8'h77,16'h0}, '{1,0,1,0,0,0,8'h22,8'h00,8'h00,16'h0},
    '{3,0,1,0,0,0,8'h13,8'h01,8'h00,16'h0}, '{1,0,0,0,0,1,8'h22,8'h00,8'h08,16'h0},
    '{3,0,0,0,0,1,8'h13,8'h00,8'h01,16'h0}, '{1,0,1,0,0,0,8'hAA,8'hFF,8'h00,16'h0},
    '{1,0,0,0,0,1,8'hAA,8'h00,8'h01,16'h0}, '{1,0,1,1,0,0,8'h00,8'h34,8'h00,16'h0},
    '{6,0,1,0,0,0,8'h00,8'h66,8'h00,16'h0}, '{6,0,0,0,1,1,8'h00,8'h00,8'h66,16'h1734},
    '{7,0,0,0,1,0,8'h00,8'h00,8'h00,16'h3DFF}, '{7,0,0,0,1,0,8'h00,8'h00,8'h00,16'h3E00}};
  msd_decoder DUT (.CLK(clk), .RST(rst), .OP_VALID(op_v), .OP_KIND(op_k), .OP_WRITE(op_w),
    .OP_ADDR(op_a), .OP_REG_SEL(op_r), .OP_USE_REG(op_u), .OP_WIDE(op_x), .OP_WIDE_ADDR(op_wa),
    .OP_WDATA(op_d), .OP_BIT_WDATA(op_d[0]), .FLASH_WRITE_EN(fl_en), .RESP_VALID(resp_v),
    .RESP_RDATA(rd), .RESP_BIT(rbit), .SFR_SEL(), .SFR_WRITE(), .SFR_ADDR(), .SFR_WDATA(),
    .FLASH_READ(), .FLASH_WRITE(fwr), .FLASH_ADDR(faddr), .FLASH_RESERVED(), .FLASH_LOCK_SEL(),
    .FLASH_WDATA(fwd), .STACK_POINTER(sp), .ACTIVE_BANK(bank), .ONCHIP_EXTERNAL_RAM_PAGE_BIT(pg));
  msd_flash_model flash (.clk(clk), .wr(fwr), .addr(faddr), .wdata(fwd));
  task automatic final_report;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk8({7'h0, g}, {7'h0, e});
  endtask
  // The request pulse is one cycle; operands stay put until the next request.
  task automatic acc(input msd_row_t q);
    int t;
    {op_k, op_r, op_w, op_u, op_x} = {q.k, q.r, q.w, q.u, q.x};
    {op_a, op_d, op_wa} = {q.a, q.d, q.wa};
    op_v = 1'b1;
    @(posedge clk) #1 op_v = 1'b0;
    t = 0;
    while (resp_v !== 1'b1 && t < 9) begin
      @(posedge clk) #1 t++;
    end
    if (t == 9) chk8(8'h00, 8'h01);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    {rst, op_v, op_k, op_r, op_w, op_u, op_x, op_a, op_d, op_wa, fl_en} = '0;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    foreach (rows[i]) begin
      acc(rows[i]);
      if (rows[i].c && rows[i].k == 3'd3) chk1(rbit, rows[i].e[0]);
      else if (rows[i].c) chk8(rd, rows[i].e);
    end
    // Stack wraps through the whole 256 bytes.
    acc('{1,0,1,0,0,0,8'h81,8'hFF,8'h00,16'h0});
    acc('{4,0,1,0,0,0,8'h00,8'h3C,8'h00,16'h0});
    chk8(sp, 8'h00);
    acc('{1,0,0,0,0,1,8'h00,8'h00,8'h00,16'h0});
    chk8(rd, 8'h3C);
    fl_en = 1'b1;
    acc('{6,0,1,0,1,0,8'h00,8'h5E,8'h00,16'h0123});
    fl_en = 1'b0;
    chk8(flash.mem[16'h0123], 8'h5E);
    chk8(8'(flash.n_wr), 8'h01);
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    chk8(sp, 8'h07);
    chk8({5'h0, pg, bank}, 8'h00);
    acc('{1,0,0,0,0,1,8'hAA,8'h00,8'h00,16'h0});
    chk8(rd, 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
